// File: hdl/ssp_defs.vh
// constants and register map of the synchronous slave serial port
// Function
// - slave mode when clocked link select set and clock source select clear
// - both receive enables clear means transmitter, either set means receiver
// - port runs only while port enable set; clearing disables it
// - first of two written characters moves to shift register at once
// - second character waits in holding register, empty flag stays clear
// - after shift-out, pending character moves to shift register; flag sets in the same cycle
// - empty flag with transmit and peripheral enables raises wake and interrupt
// - ninth transmit bit set before writing low eight bits starts transfer
// - transmission only while transmit enable is set
// - continuous receive keeps receiver live; single receive enable ignored
// - full received character moves to receive data register, also in sleep
// - ninth receive bit shown in status; read it before the data register
// - ready flag sets on full character; interrupt if receive enable set
// - overrun cleared by clearing continuous receive or port enable
// - only slave mode shifts during sleep
// - slave shift registers clocked only by external clock pin
// - reading data register unloads characters; ready clears when none remain
// - in sleep data and clock accepted; full character sets ready and wakes
// - writing the holding register clears the empty flag
// - after wake execution continues; global enable vectors to 004h
// - slave transmit in sleep takes clocks and drives data pin
// - pin functions relocatable by remap register, defaults after reset
// - data changes on leading edge, sampled on trailing edge
// - receive buffer holds two characters, oldest shown, ready while any
// - third character when full sets overrun, keeps data, blocks receive
`ifndef SSP_DEFS_VH
`define SSP_DEFS_VH
`define SSP_ADDR_W 12
`define SSP_OFF_TXCTL 12'h000
`define SSP_OFF_RXCTL 12'h004
`define SSP_OFF_TXDATA 12'h008
`define SSP_OFF_RXDATA 12'h00C
`define SSP_OFF_BAUD 12'h010
`define SSP_OFF_IRQ 12'h014
`define SSP_OFF_REMAP 12'h018
// transmit control fields
`define SSP_TX_CLOCK_SOURCE_SEL 7
`define SSP_TX_NINE 6
`define SSP_TX_EN 5
`define SSP_TX_SYNC 4
`define SSP_TX_EMPTY_SR 1
`define SSP_TX_NINTH 0
// receive control fields
`define SSP_RX_PEN 7
`define SSP_RX_NINE 6
`define SSP_RX_SINGLE_RX_ENABLE 5
`define SSP_RX_CONTINUOUS_RX_ENABLE 4
`define SSP_RX_OVR 1
`define SSP_RX_NINTH 0
// interrupt control fields
`define SSP_IRQ_GIE 7
`define SSP_IRQ_PERIPHERAL_IRQ_ENABLE 6
`define SSP_IRQ_RXIE 5
`define SSP_IRQ_TX_IRQ_ENABLE 4
`define SSP_IRQ_RXF 1
`define SSP_IRQ_TXF 0
`define SSP_BAUD_IDLE 6
`define SSP_BAUD_POL 4
`define SSP_REMAP_RST 8'h00
`define SSP_VECTOR 12'h004
`define SSP_BITS8 4'h8
`define SSP_BITS9 4'h9
`define SSP_RX_FULL 2'b10
`endif

// File: hdl/ssp_port.v
// synchronous slave serial port with apb register access
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/10ps
`include "ssp_defs.vh"
module ssp_port
(
  // clock and reset
  input wire clk,
  input wire rst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`SSP_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // link pins
  input wire clock_pin_in,
  input wire data_pin_in,
  output reg data_pin_out,
  output reg data_pin_oe,
  output reg clock_pin_oe,
  // processor side
  input wire sleep,
  output reg wake,
  output reg irq,
  output reg [11:0] irq_vector,
  output reg [7:0] pin_remap_reg
);

reg [7:0] tx_control_reg;
reg [7:0] rx_control_reg;
reg [7:0] irq_control;
reg [7:0] baud_control_reg;
reg [7:0] tx_holding_reg;
reg tx_hold_ninth;
reg tx_hold_full;
reg [8:0] tx_shift_reg;
reg tx_shift_full;
reg [3:0] tx_count;
reg tx_buffer_empty_flag;
reg [8:0] rx_shift_reg;
reg [3:0] rx_count;
reg [8:0] rx_fifo [0:1];
reg rx_head;
reg [1:0] rx_level;
reg overrun_flag;
reg ck_s1, ck_s2, ck_s3, dt_s1, dt_s2;

// register select on a word-aligned byte address
function reg_hit;
  input [`SSP_ADDR_W-1:0] a;
  input [`SSP_ADDR_W-1:0] off;
  begin
    reg_hit = (a == off);
  end
endfunction

function [7:0] sel_byte;
  input [8:0] v;
  begin
    sel_byte = v[7:0];
  end
endfunction

function data_pin_in_s;
  input v;
  begin
    data_pin_in_s = v;
  end
endfunction

// mode decode
wire port_enable = rx_control_reg[`SSP_RX_PEN];
wire continuous_rx_enable = rx_control_reg[`SSP_RX_CONTINUOUS_RX_ENABLE];
wire single_rx_enable = rx_control_reg[`SSP_RX_SINGLE_RX_ENABLE];
wire slave_mode = port_enable & tx_control_reg[`SSP_TX_SYNC] & ~tx_control_reg[`SSP_TX_CLOCK_SOURCE_SEL];
wire rx_mode = single_rx_enable | continuous_rx_enable;
wire transmit_enable = tx_control_reg[`SSP_TX_EN];
wire rx_ready_flag = (rx_level != 2'b00);
wire [3:0] tx_bits = tx_control_reg[`SSP_TX_NINE] ? `SSP_BITS9 : `SSP_BITS8;
wire [3:0] rx_bits = rx_control_reg[`SSP_RX_NINE] ? `SSP_BITS9 : `SSP_BITS8;
// polarity select flips which pin edge is leading
wire ck_now = ck_s2 ^ baud_control_reg[`SSP_BAUD_POL];
wire ck_old = ck_s3 ^ baud_control_reg[`SSP_BAUD_POL];
wire lead_edge = ck_now & ~ck_old;
wire trail_edge = ~ck_now & ck_old;
wire wr = psel & penable & pwrite;
wire rd = psel & penable & ~pwrite;
// one decode per register, shared by the write side and the pop
wire rd_data = rd & reg_hit(paddr, `SSP_OFF_RXDATA);
wire wr_hold = wr & reg_hit(paddr, `SSP_OFF_TXDATA);
wire wr_txctl = wr & reg_hit(paddr, `SSP_OFF_TXCTL);
wire wr_rxctl = wr & reg_hit(paddr, `SSP_OFF_RXCTL);
wire wr_irq = wr & reg_hit(paddr, `SSP_OFF_IRQ);
wire wr_baud = wr & reg_hit(paddr, `SSP_OFF_BAUD);
wire wr_remap = wr & reg_hit(paddr, `SSP_OFF_REMAP);
wire bad_addr = (paddr > `SSP_OFF_REMAP) | (paddr[1:0] != 2'b00);
wire rx_done = slave_mode & rx_mode & continuous_rx_enable & trail_edge & (rx_count == rx_bits - 4'h1);
wire [8:0] rx_char = rx_control_reg[`SSP_RX_NINE] ? {data_pin_in_s(dt_s2), rx_shift_reg[8:1]}
  : {1'b0, data_pin_in_s(dt_s2), rx_shift_reg[8:2]};
wire tx_active = slave_mode & ~rx_mode & transmit_enable;
wire tx_last = tx_active & tx_shift_full & trail_edge & (tx_count == tx_bits - 4'h1);
wire tx_event = tx_buffer_empty_flag & irq_control[`SSP_IRQ_TX_IRQ_ENABLE] & irq_control[`SSP_IRQ_PERIPHERAL_IRQ_ENABLE];
wire rx_event = rx_ready_flag & irq_control[`SSP_IRQ_RXIE] & irq_control[`SSP_IRQ_PERIPHERAL_IRQ_ENABLE];
// buffer moves: a pop and a store may fall in one cycle
wire rx_take = rd_data & rx_ready_flag;
wire rx_store = rx_done & ~overrun_flag & (rx_level != `SSP_RX_FULL);
wire tx_move = tx_hold_full & (~tx_shift_full | tx_last);

// link pins pass two flops; the third only delays for edge finding
always @(posedge clk or posedge rst)
begin
  if (rst)
  begin
    ck_s1 <= 1'b0;
    ck_s2 <= 1'b0;
    ck_s3 <= 1'b0;
    dt_s1 <= 1'b0;
    dt_s2 <= 1'b0;
  end
  else
  begin
    ck_s1 <= clock_pin_in;
    ck_s2 <= ck_s1;
    ck_s3 <= ck_s2;
    dt_s1 <= data_pin_in;
    dt_s2 <= dt_s1;
  end
end

// software-written control registers; status bits are read from live state
always @(posedge clk or posedge rst)
begin
  if (rst)
  begin
    tx_control_reg <= 8'h00;
    rx_control_reg <= 8'h00;
    irq_control <= 8'h00;
    baud_control_reg <= 8'h00;
    pin_remap_reg <= `SSP_REMAP_RST;
  end
  else
  begin
    if (wr_txctl)
    begin
      tx_control_reg <= {pwdata[7:2], 1'b0, pwdata[0]};
    end
    if (wr_rxctl)
    begin
      rx_control_reg <= {pwdata[7:2], 2'b00};
    end
    if (wr_irq)
    begin
      irq_control <= {pwdata[7:4], 4'h0};
    end
    if (wr_baud)
    begin
      baud_control_reg <= {3'b000, pwdata[4], 4'h0};
    end
    if (wr_remap)
    begin
      pin_remap_reg <= pwdata[7:0];
    end
  end
end

// the clock pin is never driven in slave mode; the data pin whenever the slave transmitter is enabled, idle or not
always @(posedge clk or posedge rst)
begin
  if (rst)
  begin
    data_pin_oe <= 1'b0;
    clock_pin_oe <= 1'b0;
  end
  else
  begin
    clock_pin_oe <= 1'b0;
    data_pin_oe <= tx_active;
  end
end

// transmit holding and shift registers
always @(posedge clk or posedge rst)
begin
  if (rst)
  begin
    tx_holding_reg <= 8'h00;
    tx_hold_ninth <= 1'b0;
    tx_hold_full <= 1'b0;
    tx_shift_reg <= 9'h000;
    tx_shift_full <= 1'b0;
    tx_count <= 4'h0;
    data_pin_out <= 1'b0;
  end
  else if (!port_enable)
  begin
    tx_hold_full <= 1'b0;
    tx_shift_full <= 1'b0;
    tx_count <= 4'h0;
    data_pin_out <= 1'b0;
  end
  else
  begin
    if (tx_active && tx_shift_full && lead_edge)
    begin
      data_pin_out <= tx_shift_reg[tx_count];
    end
    if (tx_active && tx_shift_full && trail_edge)
    begin
      tx_count <= tx_count + 4'h1;
    end
    if (tx_last)
    begin
      tx_count <= 4'h0;
      tx_shift_full <= 1'b0;
    end
    if (tx_move)
    begin
      tx_shift_reg <= {tx_hold_ninth, tx_holding_reg};
      tx_shift_full <= 1'b1;
      tx_hold_full <= 1'b0;
      tx_count <= 4'h0;
    end
    // a write in the cycle of a move refills the holding register at once
    if (wr_hold)
    begin
      tx_holding_reg <= pwdata[7:0];
      tx_hold_ninth <= tx_control_reg[`SSP_TX_NINE] & tx_control_reg[`SSP_TX_NINTH];
      tx_hold_full <= 1'b1;
    end
  end
end

// holding-register empty flag; a new write wins over a move in one cycle
always @(posedge clk or posedge rst)
begin
  if (rst)
  begin
    tx_buffer_empty_flag <= 1'b1;
  end
  else if (!port_enable)
  begin
    tx_buffer_empty_flag <= 1'b1;
  end
  else if (wr_hold)
  begin
    tx_buffer_empty_flag <= 1'b0;
  end
  else if (!tx_hold_full || tx_move)
  begin
    tx_buffer_empty_flag <= 1'b1;
  end
end

// receive shift register and bit counter; a cleared receive drops a partial character
always @(posedge clk or posedge rst)
begin
  if (rst)
  begin
    rx_shift_reg <= 9'h000;
    rx_count <= 4'h0;
  end
  else if (!port_enable || !continuous_rx_enable)
  begin
    rx_count <= 4'h0;
  end
  else if (rx_done)
  begin
    rx_count <= 4'h0;
  end
  else if (slave_mode && trail_edge)
  begin
    rx_shift_reg <= {dt_s2, rx_shift_reg[8:1]};
    rx_count <= rx_count + 4'h1;
  end
end

// two character receive buffer and overrun
always @(posedge clk or posedge rst)
begin
  if (rst)
  begin
    rx_fifo[0] <= 9'h000;
    rx_fifo[1] <= 9'h000;
    rx_head <= 1'b0;
    rx_level <= 2'b00;
    overrun_flag <= 1'b0;
  end
  else if (!port_enable)
  begin
    rx_level <= 2'b00;
    rx_head <= 1'b0;
    overrun_flag <= 1'b0;
  end
  else
  begin
    if (!continuous_rx_enable)
    begin
      overrun_flag <= 1'b0;
    end
    else if (rx_done && rx_level == `SSP_RX_FULL)
    begin
      overrun_flag <= 1'b1;
    end
    if (rx_store)
    begin
      rx_fifo[rx_head ^ rx_level[0]] <= rx_char;
      rx_level <= rx_level + 2'b01 - {1'b0, rx_take};
    end
    else if (rx_take)
    begin
      rx_level <= rx_level - 2'b01;
    end
    if (rx_take)
    begin
      rx_head <= ~rx_head;
    end
  end
end

// apb answer: one access cycle, error on a hole or a misaligned address
always @(posedge clk or posedge rst)
begin
  if (rst)
  begin
    pready <= 1'b0;
    pslverr <= 1'b0;
  end
  else
  begin
    pready <= psel & ~penable;
    pslverr <= psel & ~penable & bad_addr;
  end
end

// read data is captured in the setup cycle and stands through the access cycle
always @(posedge clk or posedge rst)
begin
  if (rst)
  begin
    prdata <= 32'h00000000;
  end
  else if (psel && !penable)
  begin
    prdata <= 32'h00000000;
    case (paddr)
      `SSP_OFF_TXCTL: prdata[7:0] <= {tx_control_reg[7:2], ~tx_shift_full, tx_control_reg[0]};
      `SSP_OFF_RXCTL: prdata[7:0] <= {rx_control_reg[7:2], overrun_flag, rx_fifo[rx_head][8]};
      `SSP_OFF_RXDATA: prdata[7:0] <= sel_byte(rx_fifo[rx_head]);
      `SSP_OFF_BAUD: prdata[7:0] <= {1'b0, ~(|rx_count), baud_control_reg[5:0]};
      `SSP_OFF_IRQ: prdata[7:0] <= {irq_control[7:4], 2'b00, rx_ready_flag, tx_buffer_empty_flag};
      `SSP_OFF_REMAP: prdata[7:0] <= pin_remap_reg;
      `SSP_OFF_TXDATA: prdata <= 32'h00000000;
      default: prdata <= 32'h00000000;
    endcase
  end
end

// wake and interrupt follow the enabled event levels
always @(posedge clk or posedge rst)
begin
  if (rst)
  begin
    wake <= 1'b0;
    irq <= 1'b0;
    irq_vector <= 12'h000;
  end
  else
  begin
    wake <= sleep & slave_mode & (tx_event | rx_event);
    irq <= irq_control[`SSP_IRQ_GIE] & (tx_event | rx_event);
    irq_vector <= `SSP_VECTOR;
  end
end

endmodule // ssp_port

// File: tb/ssp_link_model.sv
// external synchronous master of the link
`timescale 1ns/10ps
module ssp_link_model
(
  // link
  output reg sck,
  output reg sdo,
  input wire sdi
);
  initial
  begin
    sck = 1'b0;
    sdo = 1'b0;
  end
  // one clock per bit, lsb first, clock idle low
  task frame(input integer n, input [8:0] tx, output [8:0] rx);
    integer i;
    begin
      rx = 9'h000;
      for (i = 0; i < n; i = i + 1)
      begin
        sck = 1'b1;
        sdo = tx[i]; // new bit on leading edge
        #24;
        sck = 1'b0;
        rx[i] = sdi; // taken on trailing edge
        #24;
      end
      sdo = ~sdo;
    end
  endtask
endmodule // ssp_link_model

// File: tb/ssp_props_properties.sv
// assertions on the serial port bus and pins
`timescale 1ns/10ps
`include "ssp_defs.vh"
module ssp_props
(
  // clock and reset
  input wire clk,
  input wire rst,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`SSP_ADDR_W-1:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // pins and processor
  input wire sleep,
  input wire wake,
  input wire data_pin_oe,
  input wire clock_pin_oe,
  input wire [11:0] irq_vector,
  input wire [7:0] pin_remap_reg
);
  default clocking dcb @(posedge clk); endclocking
  default disable iff (rst);
  property p_ans; psel && !penable |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("no answer in access cycle");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  property p_err; pready |-> pslverr == (paddr > 12'h018 || paddr[1:0] != 2'h0); endproperty
  a_err: assert property (p_err) else $error("error response wrong");
  property p_wo; pready && !pwrite && paddr == `SSP_OFF_TXDATA |-> prdata == 32'h0; endproperty
  a_wo: assert property (p_wo) else $error("transmit data read not zero");
  property p_ckoe; !clock_pin_oe; endproperty
  a_ckoe: assert property (p_ckoe) else $error("clock pin driven");
  property p_vec; !rst |=> irq_vector == 12'h004; endproperty
  a_vec: assert property (p_vec) else $error("vector wrong");
  property p_remap; $fell(rst) |-> pin_remap_reg == 8'h00; endproperty
  a_remap: assert property (p_remap) else $error("remap not default");
  property p_wake; wake |-> $past(sleep); endproperty
  a_wake: assert property (p_wake) else $error("wake while awake");
  c_err: cover property (pready && pslverr);
  c_wake: cover property (wake);
  c_tx: cover property (data_pin_oe);
endmodule // ssp_props
bind ssp_port ssp_props u_props (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep(sleep), .wake(wake),
  .data_pin_oe(data_pin_oe), .clock_pin_oe(clock_pin_oe), .irq_vector(irq_vector),
  .pin_remap_reg(pin_remap_reg));

// File: tb/tb.sv
// testbench of the synchronous slave serial port
`timescale 1ns/10ps
`include "ssp_defs.vh"
module tb;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg sleep = 1'b0;
  wire [31:0] prdata;
  wire pready, pslverr, dout, doe, ckoe, wake, irq, sck, mdo;
  wire [11:0] vec;
  wire [7:0] remap;
  wire dline = doe ? dout : mdo;
  integer seed = 72306;
  integer n_fail = 0;
  integer checks = 0;
  integer cyc = 0;
  integer i;
  reg [31:0] r;
  reg e;
  reg [8:0] got;
  reg [8:0] c [0:2];
  reg [47:0] al = {12'h018, 12'h01C, 12'h002, 12'h008};
  always #2 clk = ~clk;
  ssp_port u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .clock_pin_in(sck),
    .data_pin_in(dline), .data_pin_out(dout), .data_pin_oe(doe), .clock_pin_oe(ckoe), .sleep(sleep),
    .wake(wake), .irq(irq), .irq_vector(vec), .pin_remap_reg(remap));
  ssp_link_model u_link (.sck(sck), .sdo(mdo), .sdi(dline));
  function exp_err(input [11:0] a);
    exp_err = a > 12'h018 || a[1:0] != 2'h0;
  endfunction
  task ck(input [63:0] name, input [31:0] seen, input [31:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp)
      begin
        n_fail = n_fail + 1;
        $display("Error %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [7:0] d);
    begin
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
        @(posedge clk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // a frame from the master, then time for the flags to settle
  task fr(input [3:0] n, input [8:0] d);
    begin
      u_link.frame(n, d, got);
      repeat (6) @(posedge clk);
    end
  endtask
  task final_report;
    begin
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      n_fail = n_fail + 1;
      final_report;
    end
  end
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 4; i = i + 1)
    begin
      apb(1'b0, al[i*12 +: 12], 8'h00);
      ck("err", e, exp_err(al[i*12 +: 12]));
      if (!exp_err(al[i*12 +: 12]))
        ck("rdata", r, 32'h0);
    end
    c[2] = $random(seed) & 9'h0FF;
    apb(1'b1, `SSP_OFF_REMAP, c[2][7:0]);
    @(posedge clk);
    ck("remap", remap, c[2][7:0]);
    apb(1'b0, `SSP_OFF_REMAP, 8'h00);
    ck("remaprd", r[7:0], c[2][7:0]);
    apb(1'b1, `SSP_OFF_TXCTL, 8'h10);
    apb(1'b1, `SSP_OFF_IRQ, 8'hE0);
    apb(1'b1, `SSP_OFF_RXCTL, 8'hB0);
    sleep <= 1'b1;
    for (i = 0; i < 3; i = i + 1)
    begin
      c[i] = $random(seed) & 9'h0FF;
      fr(4'h8, c[i]);
      ck("wake", wake, 1'b1);
      ck("irq", irq, 1'b1);
    end
    sleep <= 1'b0;
    apb(1'b0, `SSP_OFF_RXCTL, 8'h00);
    ck("ovr", r[1], 1'b1);
    apb(1'b0, `SSP_OFF_RXDATA, 8'h00);
    ck("rx0", r[7:0], c[0][7:0]);
    apb(1'b0, `SSP_OFF_IRQ, 8'h00);
    ck("rdy", r[1], 1'b1);
    apb(1'b0, `SSP_OFF_RXDATA, 8'h00);
    ck("rx1", r[7:0], c[1][7:0]);
    apb(1'b0, `SSP_OFF_IRQ, 8'h00);
    ck("rdy", r[1], 1'b0);
    apb(1'b1, `SSP_OFF_RXCTL, 8'h80);
    apb(1'b0, `SSP_OFF_RXCTL, 8'h00);
    ck("ovr", r[1], 1'b0);
    apb(1'b1, `SSP_OFF_RXCTL, 8'hD0);
    c[0] = $random(seed);
    fr(4'h9, c[0]);
    apb(1'b0, `SSP_OFF_RXCTL, 8'h00);
    ck("rx9", r[0], c[0][8]);
    apb(1'b0, `SSP_OFF_RXDATA, 8'h00);
    ck("rx9lo", r[7:0], c[0][7:0]);
    apb(1'b1, `SSP_OFF_RXCTL, 8'h80);
    apb(1'b1, `SSP_OFF_IRQ, 8'h50);
    apb(1'b1, `SSP_OFF_TXCTL, 8'h30);
    c[0] = $random(seed) & 9'h0FF;
    c[1] = $random(seed) & 9'h0FF;
    apb(1'b1, `SSP_OFF_TXDATA, c[0][7:0]);
    apb(1'b1, `SSP_OFF_TXDATA, c[1][7:0]);
    apb(1'b0, `SSP_OFF_IRQ, 8'h00);
    ck("txe", r[0], 1'b0);
    sleep <= 1'b1;
    fr(4'h8, 9'h000);
    ck("tx0", got, c[0]);
    ck("wake", wake, 1'b1);
    ck("irq", irq, 1'b0);
    fr(4'h8, 9'h000);
    ck("tx1", got, c[1]);
    sleep <= 1'b0;
    apb(1'b1, `SSP_OFF_TXCTL, 8'h71);
    c[2] = $random(seed) & 9'h0FF;
    apb(1'b1, `SSP_OFF_TXDATA, c[2][7:0]);
    fr(4'h9, 9'h000);
    ck("tx9", got, c[2] | 9'h100);
    apb(1'b1, `SSP_OFF_TXCTL, 8'h10);
    apb(1'b1, `SSP_OFF_TXDATA, 8'h5A);
    ck("oe", doe, 1'b0);
    apb(1'b1, `SSP_OFF_TXCTL, 8'h30);
    apb(1'b1, `SSP_OFF_RXCTL, 8'h00);
    repeat (2) @(posedge clk);
    ck("oe", doe, 1'b0);
    ck("vec", vec, 12'h004);
    final_report;
  end
endmodule // tb
